// *** rtl/tick_timer_pkg.sv ***
package tick_timer_pkg;

    localparam int unsigned COUNT_WIDTH = 24;

    localparam logic [7:0] TICK_CONTROL_STATUS_OFS    = 8'h10;
    localparam logic [7:0] TICK_RELOAD_VALUE_OFS      = 8'h14;
    localparam logic [7:0] TICK_PRESENT_COUNT_OFS     = 8'h18;
    localparam logic [7:0] TICK_CALIBRATION_VALUE_OFS = 8'h1c;

    localparam int unsigned COUNT_ENABLE_BIT      = 0;
    localparam int unsigned TICK_IRQ_ENABLE_BIT   = 1;
    localparam int unsigned TICK_CLOCK_SELECT_BIT = 2;
    localparam int unsigned ZERO_REACHED_BIT      = 16;
    localparam int unsigned CALIBRATION_INEXACT_BIT = 30;
    localparam int unsigned REFERENCE_ABSENT_BIT    = 31;

    localparam logic [2:0]  CONTROL_RESET        = 3'h0;
    localparam logic [23:0] RELOAD_RESET         = 24'h000000;
    localparam logic [23:0] COUNT_RESET          = 24'h000000;
    localparam logic [23:0] INTERVAL_CAL_RESET   = 24'h000004;
    localparam logic        CAL_FLAG_RESET       = 1'b0;

endpackage

// *** rtl/periodic_tick_down_counter.sv ***
`timescale 1ns/100ps

module periodic_tick_down_counter #(
    parameter int unsigned WIDTH = tick_timer_pkg::COUNT_WIDTH
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        reg_sel,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic [23:0] calibration_source_field,
    input  wire logic        calibration_source_inexact,
    input  wire logic        calibration_source_absent,
    output logic      [31:0] reg_rdata,
    output logic             reg_ready,
    output logic             tick_exception
);
    import tick_timer_pkg::*;

    logic             count_enable_q;
    logic             tick_irq_enable_q;
    logic             tick_clock_select_q;
    logic             zero_reached_flag_q;
    logic [WIDTH-1:0] reload_q;
    logic [WIDTH-1:0] count_q;
    logic             half_phase_q;
    logic [23:0]      interval_calibration_q;
    logic             calibration_inexact_q;
    logic             reference_absent_q;
    logic             tick;
    logic             reach_zero;
    logic             wr_ctrl;
    logic             wr_reload;
    logic             wr_count;
    logic             rd_ctrl;

    logic [WIDTH-1:0] count_d;
    logic             zero_reached_flag_d;
    logic             tick_exception_d;
    logic             tick_exception_q;
    logic [31:0]      reg_rdata_d;
    logic [31:0]      reg_rdata_q;
    logic             reg_ready_q;

    // Address match shared by every strobe decode.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_ctrl   = reg_sel && reg_write && hit(reg_addr, TICK_CONTROL_STATUS_OFS);
    assign wr_reload = reg_sel && reg_write && hit(reg_addr, TICK_RELOAD_VALUE_OFS);
    assign wr_count  = reg_sel && reg_write && hit(reg_addr, TICK_PRESENT_COUNT_OFS);
    assign rd_ctrl   = reg_sel && !reg_write && hit(reg_addr, TICK_CONTROL_STATUS_OFS);

    // Tick pacing: full rate, or every other clock for the halved reference.
    assign tick = count_enable_q && (tick_clock_select_q || half_phase_q);

    // A decrement from one lands on zero; a zero reload parked at zero never counts again.
    assign reach_zero = tick && (count_q == WIDTH'(1));

    // A clear by write in the same cycle swallows the pulse of that arrival.
    assign tick_exception_d = reach_zero && tick_irq_enable_q && !wr_count;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            half_phase_q <= 1'b0;
        end else if (count_enable_q) begin
            half_phase_q <= !half_phase_q;
        end else begin
            half_phase_q <= 1'b0;
        end
    end

    // Reserved control bits are dropped on write and read back as zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_enable_q      <= CONTROL_RESET[COUNT_ENABLE_BIT];
            tick_irq_enable_q   <= CONTROL_RESET[TICK_IRQ_ENABLE_BIT];
            tick_clock_select_q <= CONTROL_RESET[TICK_CLOCK_SELECT_BIT];
        end else if (wr_ctrl) begin
            count_enable_q      <= reg_wdata[COUNT_ENABLE_BIT];
            tick_irq_enable_q   <= reg_wdata[TICK_IRQ_ENABLE_BIT];
            tick_clock_select_q <= reg_wdata[TICK_CLOCK_SELECT_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reload_q <= RELOAD_RESET[WIDTH-1:0];
        end else if (wr_reload) begin
            reload_q <= reg_wdata[WIDTH-1:0];
        end
    end

    // Clearing by write wins over a tick, so the next enable starts from the reload.
    always_comb begin
        count_d = count_q;
        if (wr_count) begin
            count_d = '0;
        end else if (tick) begin
            if (count_q == '0) begin
                count_d = reload_q;
            end else begin
                count_d = count_q - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_q <= COUNT_RESET[WIDTH-1:0];
        end else begin
            count_q <= count_d;
        end
    end

    // A new zero arrival outranks the clear by read, so no crossing is lost to a read; a clear by write in that cycle still drops it.
    always_comb begin
        zero_reached_flag_d = zero_reached_flag_q;
        if (wr_count) begin
            zero_reached_flag_d = 1'b0;
        end else if (reach_zero) begin
            zero_reached_flag_d = 1'b1;
        end else if (rd_ctrl) begin
            zero_reached_flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            zero_reached_flag_q <= 1'b0;
        end else begin
            zero_reached_flag_q <= zero_reached_flag_d;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tick_exception_q <= 1'b0;
        end else begin
            tick_exception_q <= tick_exception_d;
        end
    end

    // The calibration word is sampled each clock, so a change shows one clock later.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            interval_calibration_q <= INTERVAL_CAL_RESET;
            calibration_inexact_q  <= CAL_FLAG_RESET;
            reference_absent_q     <= CAL_FLAG_RESET;
        end else begin
            interval_calibration_q <= calibration_source_field;
            calibration_inexact_q  <= calibration_source_inexact;
            reference_absent_q     <= calibration_source_absent;
        end
    end

    // Read data is zero outside a read, so answers of several blocks may be ORed.
    always_comb begin
        reg_rdata_d = 32'h00000000;
        if (reg_sel && !reg_write) begin
            case (reg_addr)
                TICK_CONTROL_STATUS_OFS: begin
                    reg_rdata_d[COUNT_ENABLE_BIT]      = count_enable_q;
                    reg_rdata_d[TICK_IRQ_ENABLE_BIT]   = tick_irq_enable_q;
                    reg_rdata_d[TICK_CLOCK_SELECT_BIT] = tick_clock_select_q;
                    reg_rdata_d[ZERO_REACHED_BIT]      = zero_reached_flag_q;
                end
                TICK_RELOAD_VALUE_OFS: begin
                    reg_rdata_d[WIDTH-1:0] = reload_q;
                end
                TICK_PRESENT_COUNT_OFS: begin
                    reg_rdata_d[WIDTH-1:0] = count_q;
                end
                TICK_CALIBRATION_VALUE_OFS: begin
                    reg_rdata_d[23:0]                    = interval_calibration_q;
                    reg_rdata_d[CALIBRATION_INEXACT_BIT] = calibration_inexact_q;
                    reg_rdata_d[REFERENCE_ABSENT_BIT]    = reference_absent_q;
                end
                default: begin
                    reg_rdata_d = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= 32'h00000000;
            reg_ready_q <= 1'b0;
        end else begin
            reg_ready_q <= reg_sel;
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // Outputs are copied straight from their flip-flops.
    assign reg_rdata      = reg_rdata_q;
    assign reg_ready      = reg_ready_q;
    assign tick_exception = tick_exception_q;

endmodule

// *** verif/tick_timer_chk.sv ***
`timescale 1ns/100ps
module tick_timer_chk (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        reg_sel,
    input wire logic        reg_write,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [23:0] calibration_source_field,
    input wire logic        calibration_source_inexact,
    input wire logic        calibration_source_absent,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_ready,
    input wire logic        tick_exception
);
    import tick_timer_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    bus_ready_a: assert property (reg_sel |=> reg_ready)
        else $error("no ready after access");
    ready_idle_a: assert property (!reg_sel |=> !reg_ready)
        else $error("ready without access");
    rdata_idle_a: assert property (!reg_ready |-> reg_rdata == 32'h0)
        else $error("read data outside answer");
    write_zero_a: assert property (reg_sel && reg_write |=> reg_rdata == 32'h0)
        else $error("read data on write");
    pulse_once_a: assert property (tick_exception |=> !tick_exception)
        else $error("tick pulse too long");
    // A pulse from an arrival on the clearing edge is swallowed as well.
    clear_quiet_a: assert property (
        reg_sel && reg_write && reg_addr == TICK_PRESENT_COUNT_OFS |=> !tick_exception [*2])
        else $error("tick after clear");
    ctrl_back_a: assert property (
        reg_sel && reg_write && reg_addr == TICK_CONTROL_STATUS_OFS
        ##1 !reg_sel ##1 reg_sel && !reg_write && reg_addr == TICK_CONTROL_STATUS_OFS
        |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3))
        else $error("control bits lost");
    resv_zero_a: assert property (reg_sel && !reg_write && reg_addr == TICK_CONTROL_STATUS_OFS
        |=> reg_rdata[15:3] == 13'h0 && reg_rdata[31:17] == 15'h0)
        else $error("reserved status bits set");
    cover property (tick_exception);
    cover property (reg_sel && reg_write && reg_addr == TICK_PRESENT_COUNT_OFS);
    cover property (reg_ready && reg_rdata[16]);
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    import tick_timer_pkg::*;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        reg_sel = 1'b0;
    logic        reg_write = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [23:0] cal_field = 24'h0abcde;
    logic        cal_inexact = 1'b1;
    logic        cal_absent = 1'b0;
    logic [31:0] reg_rdata;
    logic        reg_ready;
    logic        tick_exception;
    logic [31:0] rd;
    int          n;
    int          bad_count = 0;
    int          num_checks = 0;
    always #25 clk_sys = ~clk_sys;
    periodic_tick_down_counter DUT (.clk_sys(clk_sys), .resetn(resetn), .reg_sel(reg_sel),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .calibration_source_field(cal_field), .calibration_source_inexact(cal_inexact),
        .calibration_source_absent(cal_absent), .reg_rdata(reg_rdata), .reg_ready(reg_ready),
        .tick_exception(tick_exception));
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) #1;
        {reg_sel, reg_write, reg_addr, reg_wdata} = {1'b1, w, a, d};
        @(posedge clk_sys) #1;
        reg_sel = 1'b0;
        rd = reg_rdata;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded waits: a silent timer gives a gap of 100, never a hang.
    task automatic gap();
        n = 0;
        while (tick_exception !== 1'b1 && n < 100) begin
            @(posedge clk_sys) #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_sys) #1;
            n++;
        end while (tick_exception !== 1'b1 && n < 100);
    endtask
    task automatic t_regs();
        acc(1'b0, 8'h10, 32'h0);
        cmp(rd, 32'h0);
        acc(1'b0, 8'h14, 32'h0);
        cmp(rd, 32'h0);
        acc(1'b0, 8'h1c, 32'h0);
        cmp(rd, 32'h400abcde);
        {cal_field, cal_inexact, cal_absent} = {24'h123456, 1'b0, 1'b1};
        acc(1'b0, 8'h1c, 32'h0);
        cmp(rd, 32'h80123456);
        acc(1'b0, 8'h20, 32'h0);
        cmp(rd, 32'h0);
        acc(1'b1, 8'h14, 32'h00030d3f);
        acc(1'b0, 8'h14, 32'h0);
        cmp(rd, 32'h00030d3f);
        $display("t_regs done");
    endtask
    task automatic t_full();
        acc(1'b1, 8'h14, 32'h5);
        acc(1'b1, 8'h18, 32'h0);
        acc(1'b1, 8'h10, 32'h7);
        gap();
        cmp(n, 32'd6);
        acc(1'b1, 8'h10, 32'h0);
        acc(1'b0, 8'h10, 32'h0);
        cmp(rd, 32'h00010000);
        acc(1'b0, 8'h10, 32'h0);
        cmp(rd, 32'h0);
        acc(1'b0, 8'h18, 32'h0);
        cmp(rd, 32'h4);
        acc(1'b0, 8'h18, 32'h0);
        cmp(rd, 32'h4);
        $display("t_full done");
    endtask
    task automatic t_half();
        acc(1'b1, 8'h18, 32'h0);
        acc(1'b1, 8'h10, 32'h3);
        gap();
        cmp(n, 32'd12);
        $display("t_half done");
    endtask
    task automatic t_noirq();
        acc(1'b1, 8'h10, 32'h5);
        gap();
        cmp(n, 32'd100);
        acc(1'b0, 8'h10, 32'h0);
        cmp(rd, 32'h00010005);
        acc(1'b1, 8'h14, 32'h64);
        acc(1'b1, 8'h18, 32'h0);
        acc(1'b0, 8'h10, 32'h0);
        cmp(rd, 32'h5);
        acc(1'b0, 8'h18, 32'h0);
        cmp(rd, 32'h62);
        $display("t_noirq done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 resetn = 1'b1;
        t_regs();
        t_full();
        t_half();
        t_noirq();
        close_out();
    end
    initial begin
        #100000;
        bad_count++;
        close_out();
    end
endmodule
bind periodic_tick_down_counter tick_timer_chk CHK (.clk_sys(clk_sys), .resetn(resetn),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .calibration_source_field(calibration_source_field), .reg_rdata(reg_rdata),
    .calibration_source_inexact(calibration_source_inexact), .reg_ready(reg_ready),
    .calibration_source_absent(calibration_source_absent), .tick_exception(tick_exception));
